// [rtl/cbp_pkg.sv]
// Constants shared by the management parity port and its register store.
package cbp_pkg;
    localparam int unsigned CBP_CLK_HZ = 100_000_000;
    localparam int unsigned CBP_BYTE_CLK_HZ = 12_500_000;
    localparam int unsigned CBP_BYTE_DIV = CBP_CLK_HZ / CBP_BYTE_CLK_HZ;
    localparam int unsigned CBP_DIV_W = 3;
    localparam logic [CBP_DIV_W-1:0] CBP_DIV_LAST =
        CBP_DIV_W'(CBP_BYTE_DIV - 1);
    localparam int unsigned CBP_ADDR_W = 5;
    localparam int unsigned CBP_DATA_W = 8;
    localparam int unsigned CBP_NUM_REGS = 32;
    localparam logic [CBP_ADDR_W-1:0] CBP_ICR_ADDR = 5'h04;
    localparam int unsigned CBP_ICR_PERR_BIT = 0;
    localparam logic [CBP_DATA_W-1:0] CBP_REG_RST = 8'h00;
    localparam int unsigned CBP_TX_W = 10;
    localparam int unsigned CBP_RX_W = 10;

    typedef enum logic [1:0] {
        CBP_IDLE = 2'b00,
        CBP_LOOKUP = 2'b01,
        CBP_ACKED = 2'b11,
        CBP_RELEASE = 2'b10
    } cbp_state_t;
endpackage : cbp_pkg

// [rtl/cbp_port.sv]
// Management port with odd parity, register access and clock handling.

// Behaviour
// - Parity is checked on writes only while the check enable is high.
// - Every read drives a parity bit whatever the check enable is.
// - Data byte plus parity bit always hold an odd number of ones.
// - Read data and parity stay valid while acknowledge is held low.
// - A checked write with bad parity is dropped and sets the error flag.
// - Core logic and port latching run on the local byte clock rate.
// - Serial receive data is captured on receive bit clock edges.
// - Serial transmit data is clocked out on transmit bit clock edges.
// - The shift register loads on the transmit byte clock only.
// - Acknowledge goes low at completion and stays low while selected.
// - A five-bit address picks one of thirty-two byte registers.
module cbp_port
    import cbp_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic mgmt_cs_n_i,
    input wire logic mgmt_rw_i,
    input wire logic [CBP_ADDR_W-1:0] mgmt_reg_addr_i,
    input wire logic [CBP_DATA_W-1:0] mgmt_data_bus_i,
    input wire logic mgmt_parity_bit_i,
    input wire logic mgmt_parity_check_en_i,
    input wire logic rx_bit_clk_i,
    input wire logic rx_data_i,
    input wire logic tx_bit_clk_i,
    input wire logic tx_byte_clk_i,
    input wire logic [CBP_TX_W-1:0] tx_symbol_i,
    output logic [CBP_DATA_W-1:0] mgmt_data_bus_o,
    output logic mgmt_data_bus_oe_o,
    output logic mgmt_parity_bit_o,
    output logic mgmt_parity_bit_oe_o,
    output logic mgmt_ack_n_o,
    output logic mgmt_ack_n_oe_o,
    output logic mgmt_parity_err_flag_o,
    output logic [CBP_RX_W-1:0] rx_word_o,
    output logic tx_data_o
);
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    localparam int unsigned SYNC_W = 1 + 1 + CBP_ADDR_W + CBP_DATA_W + 1
        + 1 + 4;
    logic [SYNC_W-1:0] meta_ff;
    logic [SYNC_W-1:0] sync_ff;
    logic cs_n_s;
    logic rw_s;
    logic [CBP_ADDR_W-1:0] addr_s;
    logic [CBP_DATA_W-1:0] data_s;
    logic par_s;
    logic chk_en_s;
    logic rx_clk_s;
    logic rx_data_s;
    logic tx_bit_s;
    logic tx_byte_s;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_ff <= '1;
            sync_ff <= '1;
        end else begin
            meta_ff <= {mgmt_cs_n_i, mgmt_rw_i, mgmt_reg_addr_i,
                        mgmt_data_bus_i, mgmt_parity_bit_i,
                        mgmt_parity_check_en_i, rx_bit_clk_i, rx_data_i,
                        tx_bit_clk_i, tx_byte_clk_i};
            sync_ff <= meta_ff;
        end
    end

    assign {cs_n_s, rw_s, addr_s, data_s, par_s, chk_en_s, rx_clk_s,
            rx_data_s, tx_bit_s, tx_byte_s} = sync_ff;

    // ************************************************************
    // Byte clock enable
    // ************************************************************
    // One clock only, so the 12.5 MHz byte rate is a one-cycle tick.
    logic [CBP_DIV_W-1:0] div_ff;
    logic byte_tick;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_ff <= '0;
        end else if (div_ff == CBP_DIV_LAST) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + CBP_DIV_W'(1);
        end
    end

    assign byte_tick = (div_ff == CBP_DIV_LAST);

    // ************************************************************
    // Cycle sequencer
    // ************************************************************
    cbp_state_t state_ff;
    cbp_state_t nxt_state;
    logic par_ok;
    logic wr_ok;
    logic wr_en;
    logic [CBP_DATA_W-1:0] rd_data;

    assign par_ok = ^{data_s, par_s};
    assign wr_ok = par_ok || !chk_en_s;
    assign wr_en = byte_tick && state_ff == CBP_LOOKUP && !rw_s
        && wr_ok && !cs_n_s;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            CBP_IDLE: begin
                if (!cs_n_s) begin
                    nxt_state = CBP_LOOKUP;
                end
            end
            CBP_LOOKUP: begin
                nxt_state = cs_n_s ? CBP_RELEASE : CBP_ACKED;
            end
            CBP_ACKED: begin
                if (cs_n_s) begin
                    nxt_state = CBP_RELEASE;
                end
            end
            CBP_RELEASE: begin
                nxt_state = CBP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_ff <= CBP_IDLE;
        end else if (byte_tick) begin
            state_ff <= nxt_state;
        end
    end

    // Address is held by the host, so the store reads it continuously.
    cbp_reg_store u_store (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_en_i(wr_en && addr_s != CBP_ICR_ADDR),
        .addr_i(addr_s),
        .wr_data_i(data_s),
        .rd_data_o(rd_data)
    );

    // ************************************************************
    // Parity error flag
    // ************************************************************
    // Writing a one to the flag bit of the condition register clears it;
    // a new error in the same cycle wins.
    logic perr_set;
    logic perr_clr;

    assign perr_set = byte_tick && state_ff == CBP_LOOKUP && !rw_s
        && !cs_n_s && !wr_ok;
    assign perr_clr = wr_en && addr_s == CBP_ICR_ADDR
        && data_s[CBP_ICR_PERR_BIT];

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mgmt_parity_err_flag_o <= 1'b0;
        end else if (perr_set) begin
            mgmt_parity_err_flag_o <= 1'b1;
        end else if (perr_clr) begin
            mgmt_parity_err_flag_o <= 1'b0;
        end
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    logic [CBP_DATA_W-1:0] rd_merged;

    always_comb begin
        rd_merged = rd_data;
        if (addr_s == CBP_ICR_ADDR) begin
            rd_merged = '0;
            rd_merged[CBP_ICR_PERR_BIT] = mgmt_parity_err_flag_o;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mgmt_data_bus_o <= '0;
            mgmt_parity_bit_o <= 1'b1;
        end else if (byte_tick && state_ff == CBP_LOOKUP && rw_s) begin
            mgmt_data_bus_o <= rd_merged;
            mgmt_parity_bit_o <= ~^rd_merged;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mgmt_data_bus_oe_o <= 1'b0;
            mgmt_parity_bit_oe_o <= 1'b0;
            mgmt_ack_n_oe_o <= 1'b0;
        end else if (byte_tick) begin
            // Bus drive holds for the whole acknowledged read.
            mgmt_data_bus_oe_o <= nxt_state == CBP_ACKED
                && rw_s;
            mgmt_parity_bit_oe_o <= nxt_state == CBP_ACKED && rw_s;
            mgmt_ack_n_oe_o <= nxt_state == CBP_ACKED;
        end
    end

    // Open-drain acknowledge only ever pulls low.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mgmt_ack_n_o <= 1'b0;
        end else begin
            mgmt_ack_n_o <= 1'b0;
        end
    end

    // ************************************************************
    // Serial clocks
    // ************************************************************
    // The bit clocks are only sampled here, so edges faster than half of
    // clk_i are missed; the serial shift registers sit in this block on clk_i.
    logic rx_clk_d_ff;
    logic tx_bit_d_ff;
    logic tx_byte_d_ff;
    logic [CBP_RX_W-1:0] rx_shift_ff;
    logic [CBP_TX_W-1:0] tx_shift_ff;

    // Edge detectors start at the synchronisers' reset level of one, so
    // leaving reset never shows a false rising edge on a low clock pin.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_clk_d_ff <= 1'b1;
            tx_bit_d_ff <= 1'b1;
            tx_byte_d_ff <= 1'b1;
        end else begin
            rx_clk_d_ff <= rx_clk_s;
            tx_bit_d_ff <= tx_bit_s;
            tx_byte_d_ff <= tx_byte_s;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_shift_ff <= '0;
        end else if (rx_clk_s && !rx_clk_d_ff) begin
            rx_shift_ff <= {rx_shift_ff[CBP_RX_W-2:0],
                            rx_data_s};
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_word_o <= '0;
        end else if (byte_tick) begin
            rx_word_o <= rx_shift_ff;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_shift_ff <= '0;
        end else if (tx_byte_s && !tx_byte_d_ff) begin
            tx_shift_ff <= tx_symbol_i;
        end else if (tx_bit_s && !tx_bit_d_ff) begin
            tx_shift_ff <= {tx_shift_ff[CBP_TX_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_data_o <= 1'b0;
        end else if (tx_bit_s && !tx_bit_d_ff) begin
            tx_data_o <= tx_shift_ff[CBP_TX_W-1];
        end
    end
endmodule : cbp_port

// [rtl/cbp_reg_store.sv]
// Thirty-two byte-wide internal registers with a registered read port.
module cbp_reg_store
    import cbp_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_en_i,
    input wire logic [CBP_ADDR_W-1:0] addr_i,
    input wire logic [CBP_DATA_W-1:0] wr_data_i,
    output logic [CBP_DATA_W-1:0] rd_data_o
);
    logic [CBP_DATA_W-1:0] mem_ff [CBP_NUM_REGS];

    genvar g;
    generate
        for (g = 0; g < CBP_NUM_REGS; g++) begin : g_reg
            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    mem_ff[g] <= CBP_REG_RST;
                end else if (wr_en_i && addr_i == CBP_ADDR_W'(g)) begin
                    mem_ff[g] <= wr_data_i;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_data_o <= CBP_REG_RST;
        end else begin
            rd_data_o <= mem_ff[addr_i];
        end
    end
endmodule : cbp_reg_store

// [testbench/cbp_host_model.sv]
// Host processor model that runs one management cycle per call.
module cbp_host_model (
    input wire logic clk_i,
    input wire logic ack_n_i,
    input wire logic [7:0] data_i,
    input wire logic par_i,
    output logic cs_n_o,
    output logic rw_o,
    output logic [4:0] addr_o,
    output logic [7:0] data_o,
    output logic par_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n_o = 1'h1;
        rw_o = 1'h1;
        addr_o = 5'h00;
        data_o = 8'h00;
        par_o = 1'h1;
    end
    // Released lines show the inverse so a stale value never passes.
    task automatic xfer(input logic rw, input logic [4:0] a,
        input logic [7:0] d, input logic bad, output logic [7:0] rd,
        output logic rp, output logic ok);
        int n;
        n = 0;
        cs_n_o <= 1'h0;
        rw_o <= rw;
        addr_o <= a;
        data_o <= d;
        par_o <= ~^d ^ bad;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_n_i !== 1'h0 && n < 40);
        ok = (ack_n_i === 1'h0);
        rd = data_i;
        rp = par_i;
        cs_n_o <= 1'h1;
        data_o <= ~d;
        par_o <= ~par_o;
        addr_o <= ~a;
        while (ack_n_i !== 1'h1 && n < 80) begin
            @(posedge clk_i);
            n++;
        end
        repeat (16) @(posedge clk_i);
    endtask : xfer
endmodule : cbp_host_model

// [testbench/cbp_port_props.sv]
// Concurrent checks on the management port handshake and parity.
module cbp_port_props
    import cbp_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic mgmt_cs_n_i,
    input wire logic mgmt_rw_i,
    input wire logic [CBP_DATA_W-1:0] mgmt_data_bus_i,
    input wire logic mgmt_parity_bit_i,
    input wire logic mgmt_parity_check_en_i,
    input wire logic [CBP_DATA_W-1:0] mgmt_data_bus_o,
    input wire logic mgmt_data_bus_oe_o,
    input wire logic mgmt_parity_bit_o,
    input wire logic mgmt_parity_bit_oe_o,
    input wire logic mgmt_ack_n_o,
    input wire logic mgmt_ack_n_oe_o,
    input wire logic mgmt_parity_err_flag_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // The select passes a synchroniser and two byte ticks first.
    sequence s_no_ack;
        !mgmt_ack_n_oe_o [*8];
    endsequence
    sequence s_ack_due;
        ##[1:12] mgmt_ack_n_oe_o;
    endsequence
    chk_ack_timing: assert property (
        $fell(mgmt_cs_n_i) |-> s_no_ack ##0 s_ack_due)
        else $error("acknowledge out of its window");
    chk_ack_holds: assert property (
        mgmt_ack_n_oe_o && !mgmt_cs_n_i |=> mgmt_ack_n_oe_o)
        else $error("acknowledge dropped while selected");
    chk_ack_release: assert property (
        $rose(mgmt_cs_n_i) |-> ##[1:14] !mgmt_ack_n_oe_o)
        else $error("acknowledge not released");
    chk_ack_pin_low: assert property (
        mgmt_ack_n_oe_o |-> !mgmt_ack_n_o)
        else $error("acknowledge driven high");
    chk_read_drive: assert property (
        $rose(mgmt_ack_n_oe_o) && mgmt_rw_i |->
        mgmt_data_bus_oe_o && mgmt_parity_bit_oe_o)
        else $error("read not driven");
    chk_read_parity: assert property (
        mgmt_parity_bit_oe_o |-> ^{mgmt_data_bus_o, mgmt_parity_bit_o})
        else $error("read parity even");
    chk_read_hold: assert property (
        mgmt_data_bus_oe_o && $past(mgmt_data_bus_oe_o) |->
        $stable(mgmt_data_bus_o) && $stable(mgmt_parity_bit_o))
        else $error("read data moved");
    chk_write_quiet: assert property (
        $rose(mgmt_ack_n_oe_o) && !mgmt_rw_i |-> !mgmt_data_bus_oe_o)
        else $error("write cycle drove the bus");
    chk_flag_cause: assert property (
        $rose(mgmt_parity_err_flag_o) |-> !mgmt_cs_n_i && !mgmt_rw_i &&
        mgmt_parity_check_en_i && !(^{mgmt_data_bus_i, mgmt_parity_bit_i}))
        else $error("flag set without a checked bad write");
    chk_flag_acked: assert property (
        $rose(mgmt_parity_err_flag_o) |-> ##[0:1] mgmt_ack_n_oe_o)
        else $error("dropped write not acknowledged");
endmodule : cbp_port_props

bind cbp_port cbp_port_props chk_u (.*);

// [testbench/tb.sv]
// Self-checking bench for the management parity port.
module tb
    import cbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic rw;
        logic [4:0] a;
        logic [7:0] d;
        logic en;
        logic bad;
        logic [7:0] exp;
        logic flg;
    } cbp_row_t;
    localparam logic [9:0] RX_WORD = 10'h135;
    logic clk_i, sys_rst_i, mgmt_cs_n_i, mgmt_rw_i, mgmt_parity_bit_i;
    logic mgmt_parity_check_en_i, rx_bit_clk_i, rx_data_i;
    logic tx_bit_clk_i, tx_byte_clk_i, h_par, rp, ok, ack_line;
    logic [4:0] mgmt_reg_addr_i;
    logic [7:0] mgmt_data_bus_i, mgmt_data_bus_o, h_data, rd;
    logic [9:0] tx_symbol_i, rx_word_o;
    logic mgmt_data_bus_oe_o, mgmt_parity_bit_o, mgmt_parity_bit_oe_o;
    logic mgmt_ack_n_o, mgmt_ack_n_oe_o, mgmt_parity_err_flag_o;
    logic tx_data_o;
    int fails = 0;
    int checks_done = 0;
    int cyc = 0;
    cbp_row_t rows[10] = '{
        '{1'h1, 5'h1f, 8'h00, 1'h1, 1'h0, 8'h00, 1'h0},
        '{1'h0, 5'h03, 8'ha5, 1'h1, 1'h0, 8'h00, 1'h0},
        '{1'h1, 5'h03, 8'h00, 1'h1, 1'h0, 8'ha5, 1'h0},
        '{1'h0, 5'h03, 8'h3c, 1'h1, 1'h1, 8'h00, 1'h1},
        '{1'h1, 5'h03, 8'h00, 1'h0, 1'h0, 8'ha5, 1'h1},
        '{1'h1, 5'h04, 8'h00, 1'h1, 1'h0, 8'h01, 1'h1},
        '{1'h0, 5'h1f, 8'hff, 1'h0, 1'h1, 8'h00, 1'h1},
        '{1'h1, 5'h1f, 8'h00, 1'h1, 1'h0, 8'hff, 1'h1},
        '{1'h0, 5'h04, 8'h01, 1'h1, 1'h0, 8'h00, 1'h0},
        '{1'h1, 5'h04, 8'h00, 1'h1, 1'h0, 8'h00, 1'h0}};
    // Open-drain lines: the port wins the bus whenever it drives.
    assign ack_line = mgmt_ack_n_oe_o ? mgmt_ack_n_o : 1'h1;
    assign mgmt_data_bus_i = mgmt_data_bus_oe_o ? mgmt_data_bus_o : h_data;
    assign mgmt_parity_bit_i = mgmt_parity_bit_oe_o ? mgmt_parity_bit_o :
        h_par;
    cbp_port dut_u (.*);
    cbp_host_model host_u (.clk_i(clk_i), .ack_n_i(ack_line),
        .data_i(mgmt_data_bus_i), .par_i(mgmt_parity_bit_i),
        .cs_n_o(mgmt_cs_n_i), .rw_o(mgmt_rw_i), .addr_o(mgmt_reg_addr_i),
        .data_o(h_data), .par_o(h_par));
    always #5 clk_i = ~clk_i;
    task automatic check(input logic [9:0] got, input logic [9:0] exp,
        input string m);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks_done %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        clk_i = 1'h0;
        sys_rst_i = 1'h1;
        {mgmt_parity_check_en_i, rx_bit_clk_i, rx_data_i} = 3'h4;
        {tx_bit_clk_i, tx_byte_clk_i} = 2'h0;
        tx_symbol_i = 10'h2c1;
        repeat (6) @(posedge clk_i);
        check(mgmt_data_bus_oe_o, 1'h0, "oe in reset");
        check(mgmt_parity_bit_o, 1'h1, "parity in reset");
        check(mgmt_parity_err_flag_o, 1'h0, "flag in reset");
        sys_rst_i <= 1'h0;
        foreach (rows[i]) begin
            mgmt_parity_check_en_i <= rows[i].en;
            host_u.xfer(rows[i].rw, rows[i].a, rows[i].d, rows[i].bad,
                rd, rp, ok);
            check(ok, 1'h1, "no acknowledge");
            check(ack_line, 1'h1, "acknowledge held");
            if (rows[i].rw) begin
                check(rd, rows[i].exp, "read data");
                check(^{rd, rp}, 1'h1, "read parity");
            end
            check(mgmt_parity_err_flag_o, rows[i].flg, "flag");
        end
        // ***********************************************************
        // Serial path, bit clocks slowed so sampling can follow them.
        // ***********************************************************
        tx_byte_clk_i <= 1'h1;
        repeat (6) @(posedge clk_i);
        tx_byte_clk_i <= 1'h0;
        for (int k = 9; k >= 0; k--) begin
            rx_data_i <= RX_WORD[k];
            {rx_bit_clk_i, tx_bit_clk_i} <= 2'h0;
            repeat (4) @(posedge clk_i);
            {rx_bit_clk_i, tx_bit_clk_i} <= 2'h3;
            repeat (6) @(posedge clk_i);
            check(tx_data_o, tx_symbol_i[k], "tx bit");
        end
        repeat (12) @(posedge clk_i);
        check(rx_word_o, RX_WORD, "rx word");
        wrap_up();
    end
endmodule : tb
